// ===== hw/hlf_pkg.sv
// constants of the host link and fuse configuration register bank
// assumes one core clock at 250 MHz; the link pins arrive asynchronously
// Notes on behaviour
// - polarity bit 0: flag 0 means read
// - polarity bit 1: flag 1 means read
// - clock phase follows configuration bit 2
// - clock polarity bit sets clock idle level
// - type bit 7: 0 four-wire, 1 two-wire
// - bit 6 keeps two-wire high-speed permanently
// - bit 5 gives two-wire fast-plus timing
// - lock bit 7 locks regulator setting fuses
// - lock bit 6 locks application setting fuses
// - fusing needs selecting byte plus three bytes
// - bit 4 resets two-wire after 35 ms low
// - interrupt pin drive style and active level
package hlf_pkg;

	//----------------------------------------------------------------
	// register offsets
	//----------------------------------------------------------------
	localparam logic [8:0] SERIAL_FRAMING_SETUP_OFS  = 9'h105;
	localparam logic [8:0] LINK_SELECT_OPTIONS_OFS   = 9'h106;
	localparam logic [8:0] FUSE_LOCK_CONTROL_OFS     = 9'h140;
	localparam logic [8:0] FUSE_ARRAY_POINTER_OFS    = 9'h141;
	localparam logic [8:0] FUSE_ARRAY_WORD_OFS       = 9'h142;
	localparam logic [8:0] TIMEOUT_AND_IRQ_SETUP_OFS = 9'h143;

	//----------------------------------------------------------------
	// field positions
	//----------------------------------------------------------------
	localparam int READ_FLAG_POLARITY_BIT  = 3;
	localparam int CLOCK_PHASE_BIT         = 2;
	localparam int CLOCK_POLARITY_BIT      = 1;
	localparam int SELECT_POLARITY_BIT     = 0;
	localparam int LINK_TYPE_BIT           = 7;
	localparam int CONT_HIGH_SPEED_BIT     = 6;
	localparam int FAST_PLUS_BIT           = 5;
	localparam int LINK_SUPPLY_BIT         = 4;
	localparam int REG_FUSE_LOCK_BIT       = 7;
	localparam int APP_FUSE_LOCK_BIT       = 6;
	localparam int STUCK_TIMEOUT_EN_BIT    = 4;
	localparam int GPI_SUPPLY_BIT          = 3;
	localparam int IRQ_OPEN_DRAIN_BIT      = 1;
	localparam int IRQ_ACTIVE_HIGH_BIT     = 0;

	// writable bit masks, reserved bits read as zero
	localparam logic [7:0] FRAMING_MASK = 8'h0F;
	localparam logic [7:0] LINK_MASK    = 8'hF0;
	localparam logic [7:0] LOCK_MASK    = 8'hC0;
	localparam logic [7:0] TIMEOUT_MASK = 8'h1B;
	localparam logic [7:0] RESET_VALUE  = 8'h00;
	// pin synchronisers start at idle: {two-wire clock, data, link clock, select}
	localparam logic [3:0] PIN_SYNC_RESET = 4'h9;

	//----------------------------------------------------------------
	// four-wire frame: flag, 9 address bits, 8 data bits
	//----------------------------------------------------------------
	localparam logic [4:0] ADDR_DONE_CNT  = 5'd10;
	localparam logic [4:0] FRAME_DONE_CNT = 5'd18;

	// unlock key bytes; values are arbitrary
	localparam logic [7:0] FUSE_SELECT_BYTE = 8'h5A;
	localparam logic [7:0] FUSE_KEY_ONE     = 8'hA5;
	localparam logic [7:0] FUSE_KEY_TWO     = 8'h3C;
	localparam logic [7:0] FUSE_KEY_THREE   = 8'hC3;

	//----------------------------------------------------------------
	// timing
	//----------------------------------------------------------------
	localparam int CORE_CLK_MHZ     = 250;
	localparam int STUCK_TIMEOUT_MS = 35;
	localparam int STUCK_TIMEOUT_CYC = STUCK_TIMEOUT_MS * CORE_CLK_MHZ * 1000; // fits in 32 bits

	typedef enum logic [2:0] {
		HLF_FUSE_IDLE = 3'b000,
		HLF_FUSE_SEL  = 3'b001,
		HLF_FUSE_K1   = 3'b011,
		HLF_FUSE_K2   = 3'b010,
		HLF_FUSE_OPEN = 3'b110
	} hlf_fuse_e;

endpackage : hlf_pkg

// ===== hw/hlf_regs.sv
// host link and fuse configuration register bank with its four-wire slave
// assumes link pins and two-wire clock are asynchronous to i_core_clk
`timescale 1ns/1ps
module hlf_regs #(
	parameter int STUCK_LIMIT = hlf_pkg::STUCK_TIMEOUT_CYC
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_chip_select_n,
	input  wire logic       i_serial_clock_pin,
	input  wire logic       i_data_in,
	output logic            o_data_out,
	output logic            o_data_out_oe_n,
	input  wire logic       i_two_wire_clock,
	output logic            o_two_wire_reset,
	output logic            o_pins_link_role,
	output logic            o_continuous_high_speed_en,
	output logic            o_fast_plus_timing_en,
	output logic            o_link_supply_select,
	output logic            o_gpi_supply_select,
	output logic            o_regulator_settings_fuse_lock,
	output logic            o_application_settings_fuse_lock,
	output logic            o_fuse_unlocked,
	output logic            o_fuse_prog_strobe,
	output logic [7:0]      o_fuse_prog_addr,
	output logic [7:0]      o_fuse_prog_data,
	input  wire logic       i_irq_request,
	output logic            o_interrupt_out_pin,
	output logic            o_interrupt_out_oe_n
);

	//----------------------------------------------------------------
	// synchronisers
	//----------------------------------------------------------------
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic       sck_d_reg;

	// two flops on each asynchronous pin
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_reg <= hlf_pkg::PIN_SYNC_RESET;
			sync2_reg <= hlf_pkg::PIN_SYNC_RESET;
			sck_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {i_two_wire_clock, i_data_in, i_serial_clock_pin, i_chip_select_n};
			sync2_reg <= sync1_reg;
			sck_d_reg <= sync2_reg[1];
		end
	end
	logic [7:0] framing_reg;
	logic [7:0] link_reg;
	logic [7:0] lock_reg;
	logic [7:0] pointer_reg;
	logic [7:0] word_reg;
	logic [7:0] timeout_reg;
	// synchronised pin levels
	wire logic  cs_s  = sync2_reg[0];
	wire logic  sck_s = sync2_reg[1];
	wire logic  din_s = sync2_reg[2];
	wire logic  twc_s = sync2_reg[3];

	//----------------------------------------------------------------
	// four-wire frame engine
	//----------------------------------------------------------------
	wire logic four_wire   = !link_reg[hlf_pkg::LINK_TYPE_BIT];
	wire logic sel_act     = four_wire && (framing_reg[hlf_pkg::SELECT_POLARITY_BIT]
	                         ? cs_s : !cs_s);
	wire logic sck_edge    = sck_s ^ sck_d_reg;
	wire logic leading     = sck_edge
	                         && (sck_d_reg == framing_reg[hlf_pkg::CLOCK_POLARITY_BIT]);
	wire logic sample_edge = sel_act && (framing_reg[hlf_pkg::CLOCK_PHASE_BIT]
	                         ? (sck_edge && !leading) : leading);
	wire logic shift_edge  = sel_act && sck_edge && !sample_edge;
	logic [4:0]  bit_cnt_reg;
	logic [16:0] shift_in_reg;
	logic        rd_reg;
	logic [7:0]  out_shift_reg;
	logic [16:0] shift_in_next;
	logic [7:0]  read_data;
	logic        wr_stb;
	logic [8:0]  wr_addr;
	logic [7:0]  wr_data;
	assign shift_in_next = {shift_in_reg[15:0], din_s};
	assign wr_stb  = sample_edge && !rd_reg && (bit_cnt_reg == hlf_pkg::FRAME_DONE_CNT - 5'd1);
	assign wr_addr = shift_in_reg[15:7];
	assign wr_data = shift_in_next[7:0];

	// bit counter, read flag and input shifter; counter and read flag cleared while deselected, shifter holds
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bit_cnt_reg  <= 5'd0;
			shift_in_reg <= 17'h0_0000;
			rd_reg       <= 1'b0;
		end else if (!sel_act) begin
			bit_cnt_reg <= 5'd0;
			rd_reg      <= 1'b0;
		end else if (sample_edge && bit_cnt_reg < hlf_pkg::FRAME_DONE_CNT) begin
			bit_cnt_reg  <= bit_cnt_reg + 5'd1;
			shift_in_reg <= shift_in_next;
			if (bit_cnt_reg == 5'd0) begin
				rd_reg <= (din_s == framing_reg[hlf_pkg::READ_FLAG_POLARITY_BIT]);
			end
		end
	end

	// register read mux, reserved bits zero
	always_comb begin
		case (shift_in_next[8:0])
			hlf_pkg::SERIAL_FRAMING_SETUP_OFS:  read_data = framing_reg;
			hlf_pkg::LINK_SELECT_OPTIONS_OFS:   read_data = link_reg;
			hlf_pkg::FUSE_LOCK_CONTROL_OFS:     read_data = lock_reg;
			hlf_pkg::FUSE_ARRAY_POINTER_OFS:    read_data = pointer_reg;
			hlf_pkg::FUSE_ARRAY_WORD_OFS:       read_data = word_reg;
			hlf_pkg::TIMEOUT_AND_IRQ_SETUP_OFS: read_data = timeout_reg;
			default:                            read_data = 8'h00;
		endcase
	end

	// read data out, msb first on shift edges
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			out_shift_reg   <= 8'h00;
			o_data_out      <= 1'b0;
			o_data_out_oe_n <= 1'b1;
		end else if (!sel_act) begin
			o_data_out_oe_n <= 1'b1;
		end else begin
			o_data_out_oe_n <= !rd_reg;
			if (sample_edge && bit_cnt_reg == hlf_pkg::ADDR_DONE_CNT - 5'd1) begin
				out_shift_reg <= read_data;
			end else if (shift_edge && rd_reg && bit_cnt_reg >= hlf_pkg::ADDR_DONE_CNT) begin
				o_data_out    <= out_shift_reg[7];
				out_shift_reg <= {out_shift_reg[6:0], 1'b0};
			end
		end
	end

	//----------------------------------------------------------------
	// register writes
	//----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			framing_reg <= hlf_pkg::RESET_VALUE;
			link_reg    <= hlf_pkg::RESET_VALUE;
			lock_reg    <= hlf_pkg::RESET_VALUE;
			pointer_reg <= hlf_pkg::RESET_VALUE;
			word_reg    <= hlf_pkg::RESET_VALUE;
			timeout_reg <= hlf_pkg::RESET_VALUE;
		end else if (wr_stb) begin
			case (wr_addr)
				hlf_pkg::SERIAL_FRAMING_SETUP_OFS:  framing_reg <= wr_data & hlf_pkg::FRAMING_MASK;
				hlf_pkg::LINK_SELECT_OPTIONS_OFS:   link_reg    <= wr_data & hlf_pkg::LINK_MASK;
				hlf_pkg::FUSE_LOCK_CONTROL_OFS:     lock_reg    <= wr_data & hlf_pkg::LOCK_MASK;
				hlf_pkg::FUSE_ARRAY_POINTER_OFS:    pointer_reg <= wr_data;
				hlf_pkg::FUSE_ARRAY_WORD_OFS:       word_reg    <= wr_data;
				hlf_pkg::TIMEOUT_AND_IRQ_SETUP_OFS: timeout_reg <= wr_data & hlf_pkg::TIMEOUT_MASK;
				default:                            ;
			endcase
		end
	end

	//----------------------------------------------------------------
	// fuse unlock sequence and programming strobe
	//----------------------------------------------------------------
	hlf_pkg::hlf_fuse_e fuse_state_reg;
	wire logic          wr_ptr  = wr_stb && (wr_addr == hlf_pkg::FUSE_ARRAY_POINTER_OFS);
	wire logic          wr_word = wr_stb && (wr_addr == hlf_pkg::FUSE_ARRAY_WORD_OFS);

	// selecting byte then three key bytes; any slip starts over
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fuse_state_reg <= hlf_pkg::HLF_FUSE_IDLE;
		end else if (wr_ptr || wr_word) begin
			case (fuse_state_reg)
				hlf_pkg::HLF_FUSE_IDLE: fuse_state_reg <= (wr_ptr && wr_data == hlf_pkg::FUSE_SELECT_BYTE)
				                        ? hlf_pkg::HLF_FUSE_SEL : hlf_pkg::HLF_FUSE_IDLE;
				hlf_pkg::HLF_FUSE_SEL:  fuse_state_reg <= (wr_word && wr_data == hlf_pkg::FUSE_KEY_ONE)
				                        ? hlf_pkg::HLF_FUSE_K1 : hlf_pkg::HLF_FUSE_IDLE;
				hlf_pkg::HLF_FUSE_K1:   fuse_state_reg <= (wr_word && wr_data == hlf_pkg::FUSE_KEY_TWO)
				                        ? hlf_pkg::HLF_FUSE_K2 : hlf_pkg::HLF_FUSE_IDLE;
				hlf_pkg::HLF_FUSE_K2:   fuse_state_reg <= (wr_word && wr_data == hlf_pkg::FUSE_KEY_THREE)
				                        ? hlf_pkg::HLF_FUSE_OPEN : hlf_pkg::HLF_FUSE_IDLE;
				hlf_pkg::HLF_FUSE_OPEN: fuse_state_reg <= hlf_pkg::HLF_FUSE_OPEN;
				default:                fuse_state_reg <= hlf_pkg::HLF_FUSE_IDLE;
			endcase
		end
	end

	// programming only once unlocked
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_fuse_prog_strobe <= 1'b0;
			o_fuse_prog_addr   <= 8'h00;
			o_fuse_prog_data   <= 8'h00;
			o_fuse_unlocked    <= 1'b0;
		end else begin
			o_fuse_unlocked    <= (fuse_state_reg == hlf_pkg::HLF_FUSE_OPEN);
			o_fuse_prog_strobe <= wr_word && (fuse_state_reg == hlf_pkg::HLF_FUSE_OPEN);
			if (wr_word && fuse_state_reg == hlf_pkg::HLF_FUSE_OPEN) begin
				o_fuse_prog_addr <= pointer_reg;
				o_fuse_prog_data <= wr_data;
			end
		end
	end

	//----------------------------------------------------------------
	// two-wire stuck clock timeout
	//----------------------------------------------------------------
	logic [23:0] stuck_cnt_reg;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stuck_cnt_reg    <= 24'h00_0000;
			o_two_wire_reset <= 1'b0;
		end else begin
			o_two_wire_reset <= 1'b0;
			if (twc_s || four_wire || !timeout_reg[hlf_pkg::STUCK_TIMEOUT_EN_BIT]) begin
				stuck_cnt_reg <= 24'h00_0000;
			end else if (stuck_cnt_reg < 24'(STUCK_LIMIT)) begin
				stuck_cnt_reg <= stuck_cnt_reg + 24'h00_0001;
				o_two_wire_reset <= (stuck_cnt_reg == 24'(STUCK_LIMIT - 1));
			end
		end
	end

	//----------------------------------------------------------------
	// configuration outputs and interrupt pin
	//----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pins_link_role                 <= 1'b0;
			o_continuous_high_speed_en       <= 1'b0;
			o_fast_plus_timing_en            <= 1'b0;
			o_link_supply_select             <= 1'b0;
			o_gpi_supply_select              <= 1'b0;
			o_regulator_settings_fuse_lock   <= 1'b0;
			o_application_settings_fuse_lock <= 1'b0;
			o_interrupt_out_pin              <= 1'b0;
			o_interrupt_out_oe_n             <= 1'b1;
		end else begin
			o_pins_link_role               <= four_wire;
			o_continuous_high_speed_en     <= !four_wire
			                                  && link_reg[hlf_pkg::CONT_HIGH_SPEED_BIT];
			o_fast_plus_timing_en          <= !four_wire && link_reg[hlf_pkg::FAST_PLUS_BIT];
			o_link_supply_select           <= link_reg[hlf_pkg::LINK_SUPPLY_BIT];
			o_gpi_supply_select            <= timeout_reg[hlf_pkg::GPI_SUPPLY_BIT];
			o_regulator_settings_fuse_lock <= lock_reg[hlf_pkg::REG_FUSE_LOCK_BIT];
			o_application_settings_fuse_lock <= lock_reg[hlf_pkg::APP_FUSE_LOCK_BIT];
			o_interrupt_out_pin  <= i_irq_request ~^ timeout_reg[hlf_pkg::IRQ_ACTIVE_HIGH_BIT];
			o_interrupt_out_oe_n <= timeout_reg[hlf_pkg::IRQ_OPEN_DRAIN_BIT]
			                        && !i_irq_request;
		end
	end

	//----------------------------------------------------------------
	// assertions
	//----------------------------------------------------------------
	sequence seq_flag_taken;
		sample_edge && bit_cnt_reg == 5'd0;
	endsequence
	sequence seq_stuck_low;
		!twc_s && !four_wire && timeout_reg[hlf_pkg::STUCK_TIMEOUT_EN_BIT];
	endsequence

	AST_READ_FLAG: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		seq_flag_taken |=> rd_reg == ($past(din_s) == $past(framing_reg[3])))
		else $error("read flag decoded against wrong polarity");
	AST_DESELECT_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		!sel_act |=> bit_cnt_reg == 5'd0 ##1 o_data_out_oe_n)
		else $error("frame state kept while deselected");
	AST_PIN_ROLE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		$past(i_arst_n) |-> o_pins_link_role == !$past(link_reg[7]))
		else $error("pin role does not follow link type");
	AST_HIGH_SPEED: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		o_continuous_high_speed_en |-> $past(link_reg[7] && link_reg[6]))
		else $error("high speed on without two-wire and enable");
	AST_FAST_PLUS: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		$rose(o_fast_plus_timing_en) |-> $past(link_reg[5], 1))
		else $error("fast plus set without enable");
	AST_LOCKS: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		{o_regulator_settings_fuse_lock, o_application_settings_fuse_lock} == $past(lock_reg[7:6]))
		else $error("fuse lock outputs stale");
	AST_FUSE_GATED: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		o_fuse_prog_strobe |-> $past(fuse_state_reg) == hlf_pkg::HLF_FUSE_OPEN && o_fuse_unlocked)
		else $error("fuse programmed before unlock");
	AST_STUCK_RESET: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		o_two_wire_reset |-> $past(stuck_cnt_reg == 24'(STUCK_LIMIT - 1) && !twc_s && !four_wire
		&& timeout_reg[hlf_pkg::STUCK_TIMEOUT_EN_BIT]))
		else $error("timeout reset at wrong count");
	AST_STUCK_FIRE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		seq_stuck_low ##0 stuck_cnt_reg == 24'(STUCK_LIMIT - 1) |=> o_two_wire_reset)
		else $error("no timeout reset after long low clock");
	AST_STUCK_RESTART: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		twc_s |=> stuck_cnt_reg == 24'h00_0000 && !o_two_wire_reset)
		else $error("timeout not restarted by high clock");
	AST_IRQ_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		$past(i_irq_request) |-> !o_interrupt_out_oe_n && o_interrupt_out_pin == $past(timeout_reg[0]))
		else $error("interrupt not driven to active level");

endmodule : hlf_regs

// ===== test/hlf_host_model.sv
// host side of the four-wire register link, frames paced by the core clock
// assumes the bench keeps its framing copy in step with the device
`timescale 1ns/1ps
module hlf_host_model (
	input  wire logic i_core_clk,
	output logic      o_chip_select_n,
	output logic      o_serial_clock_pin,
	output logic      o_data_out,
	input  wire logic i_data_in
);
	// framing copy: [3] read flag, [2] phase, [1] idle level, [0] select
	logic [3:0] cfg = 4'h0;

	initial begin
		o_chip_select_n    = 1'b1;
		o_serial_clock_pin = 1'b0;
		o_data_out         = 1'b0;
	end

	// half a link clock period, 40 ns
	task automatic half();
		repeat (10) @(posedge i_core_clk);
	endtask : half

	// one frame: flag, 9 address bits, 8 data bits, msb first
	task automatic xfer(input logic rd, input logic [8:0] addr, input logic [7:0] wd,
		input logic [3:0] nxt, output logic [7:0] q);
		logic [17:0] bits;
		bits = {rd ~^ cfg[3], addr, wd};
		q = 8'h00;
		@(posedge i_core_clk);
		o_chip_select_n <= cfg[0];
		half();
		for (int i = 17; i >= 0; i--) begin
			o_data_out <= bits[i];
			o_serial_clock_pin <= cfg[2] ^ cfg[1];
			half();
			if (i < 8) q[i] = i_data_in;
			o_serial_clock_pin <= ~(cfg[2] ^ cfg[1]);
			half();
		end
		o_serial_clock_pin <= cfg[1];
		half();
		// deselect at the new inactive level; data line no longer valid
		o_chip_select_n <= ~nxt[0];
		o_data_out <= ~o_data_out;
		half();
		cfg = nxt;
		o_serial_clock_pin <= nxt[1];
		half();
	endtask : xfer
endmodule : hlf_host_model

// ===== test/hlf_regs_tb_top.sv
// self-checking bench of the register bank through the four-wire link
// assumes the host model in hlf_host_model and a short stuck-clock limit
`timescale 1ns/1ps
module hlf_regs_tb_top;
	logic       i_core_clk, i_arst_n, i_chip_select_n, i_serial_clock_pin, i_data_in;
	logic       o_data_out, o_data_out_oe_n, i_two_wire_clock, o_two_wire_reset;
	logic       o_pins_link_role, o_continuous_high_speed_en, o_fast_plus_timing_en;
	logic       o_link_supply_select, o_gpi_supply_select, o_regulator_settings_fuse_lock;
	logic       o_application_settings_fuse_lock, o_fuse_unlocked, o_fuse_prog_strobe;
	logic [7:0] o_fuse_prog_addr, o_fuse_prog_data, s_addr, s_data;
	logic       i_irq_request, o_interrupt_out_pin, o_interrupt_out_oe_n;
	logic [3:0] fr = 4'h0;
	int         n_fail = 0, samples_checked = 0, n_strobe = 0, n_tmo = 0;
	logic [8:0] offs [6] = '{9'h105, 9'h106, 9'h140, 9'h141, 9'h142, 9'h143};
	logic [7:0] wv [6] = '{8'h00, 8'h7F, 8'hFF, 8'h12, 8'h3C, 8'hFF};
	logic [7:0] ex [6] = '{8'h00, 8'h70, 8'hC0, 8'h12, 8'h3C, 8'h1B};

	hlf_regs #(.STUCK_LIMIT(20)) dut_u (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_chip_select_n(i_chip_select_n),
		.i_serial_clock_pin(i_serial_clock_pin), .i_data_in(i_data_in),
		.o_data_out(o_data_out), .o_data_out_oe_n(o_data_out_oe_n),
		.i_two_wire_clock(i_two_wire_clock), .o_two_wire_reset(o_two_wire_reset),
		.o_pins_link_role(o_pins_link_role),
		.o_continuous_high_speed_en(o_continuous_high_speed_en),
		.o_fast_plus_timing_en(o_fast_plus_timing_en),
		.o_link_supply_select(o_link_supply_select),
		.o_gpi_supply_select(o_gpi_supply_select),
		.o_regulator_settings_fuse_lock(o_regulator_settings_fuse_lock),
		.o_application_settings_fuse_lock(o_application_settings_fuse_lock),
		.o_fuse_unlocked(o_fuse_unlocked), .o_fuse_prog_strobe(o_fuse_prog_strobe),
		.o_fuse_prog_addr(o_fuse_prog_addr), .o_fuse_prog_data(o_fuse_prog_data),
		.i_irq_request(i_irq_request), .o_interrupt_out_pin(o_interrupt_out_pin),
		.o_interrupt_out_oe_n(o_interrupt_out_oe_n));
	// a released data line reads inverted, so a late or missing enable spoils the read
	hlf_host_model host_u (.i_core_clk(i_core_clk), .o_chip_select_n(i_chip_select_n),
		.o_serial_clock_pin(i_serial_clock_pin), .o_data_out(i_data_in),
		.i_data_in(o_data_out ^ o_data_out_oe_n));

	initial begin
		i_core_clk = 1'b0;
		forever #2 i_core_clk = ~i_core_clk;
	end

	// count one-cycle pulses
	always @(posedge i_core_clk) begin
		if (o_fuse_prog_strobe === 1'b1) begin
			n_strobe++;
			s_addr = o_fuse_prog_addr;
			s_data = o_fuse_prog_data;
		end
		if (o_two_wire_reset === 1'b1) n_tmo++;
	end

	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : cyc

	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		logic [7:0] q;
		host_u.xfer(1'b0, a, d, (a == hlf_pkg::SERIAL_FRAMING_SETUP_OFS) ? d[3:0] : fr, q);
		if (a == hlf_pkg::SERIAL_FRAMING_SETUP_OFS) fr = d[3:0];
	endtask : wr

	task automatic rd(input string nm, input logic [8:0] a, input logic [7:0] exp);
		logic [7:0] q;
		host_u.xfer(1'b1, a, 8'h55, fr, q);
		chk(nm, q, exp);
	endtask : rd

	task automatic wrap_up();
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		#300_000;
		n_fail++;
		wrap_up();
	end

	initial begin
		i_arst_n = 1'b0;
		i_irq_request = 1'b0;
		i_two_wire_clock = 1'b1;
		cyc(5);
		chk("oe_rst", {6'h0, o_data_out_oe_n, o_interrupt_out_oe_n}, 8'h03);
		i_arst_n <= 1'b1;
		cyc(3);
		// reset values, access, unmapped place
		for (int i = 0; i < 6; i++) rd("rst", offs[i], 8'h00);
		for (int i = 1; i < 6; i++) begin
			wr(offs[i], wv[i]);
			rd("rw", offs[i], ex[i]);
		end
		wr(9'h107, 8'hFF);
		rd("unmapped", 9'h107, 8'h00);
		chk("outs", {o_pins_link_role, o_continuous_high_speed_en, o_fast_plus_timing_en,
			o_link_supply_select, o_gpi_supply_select, o_regulator_settings_fuse_lock,
			o_application_settings_fuse_lock, 1'b0}, 8'h9E);
		// interrupt drive style and level against request
		for (int v = 0; v < 8; v++) begin
			wr(hlf_pkg::TIMEOUT_AND_IRQ_SETUP_OFS, {6'h0, v[1:0]});
			i_irq_request <= v[2];
			cyc(4);
			chk("irq", {6'h0, o_interrupt_out_pin, o_interrupt_out_oe_n},
				{6'h0, ~(v[2] ^ v[0]), v[1] & ~v[2]});
		end
		i_irq_request <= 1'b0;
		// every framing combination, ending back at the default
		for (int f = 1; f <= 16; f++) begin
			wr(hlf_pkg::SERIAL_FRAMING_SETUP_OFS, {4'h0, f[3:0]});
			wr(hlf_pkg::FUSE_ARRAY_POINTER_OFS, {f[3:0], ~f[3:0]});
			rd("fr_ptr", hlf_pkg::FUSE_ARRAY_POINTER_OFS, {f[3:0], ~f[3:0]});
			rd("fr_reg", hlf_pkg::SERIAL_FRAMING_SETUP_OFS, {4'h0, f[3:0]});
		end
		// broken then complete unlock, then one programming write
		wr(hlf_pkg::FUSE_ARRAY_POINTER_OFS, 8'h5A);
		wr(hlf_pkg::FUSE_ARRAY_WORD_OFS, 8'hA5);
		wr(hlf_pkg::FUSE_ARRAY_WORD_OFS, 8'h00);
		wr(hlf_pkg::FUSE_ARRAY_WORD_OFS, 8'h3C);
		wr(hlf_pkg::FUSE_ARRAY_WORD_OFS, 8'hC3);
		chk("unlk_bad", {7'h0, o_fuse_unlocked}, 8'h00);
		wr(hlf_pkg::FUSE_ARRAY_POINTER_OFS, 8'h5A);
		wr(hlf_pkg::FUSE_ARRAY_WORD_OFS, 8'hA5);
		wr(hlf_pkg::FUSE_ARRAY_WORD_OFS, 8'h3C);
		chk("unlk_part", {7'h0, o_fuse_unlocked}, 8'h00);
		wr(hlf_pkg::FUSE_ARRAY_WORD_OFS, 8'hC3);
		chk("unlk", {7'h0, o_fuse_unlocked}, 8'h01);
		chk("no_prog", n_strobe[7:0], 8'h00);
		wr(hlf_pkg::FUSE_ARRAY_POINTER_OFS, 8'h21);
		wr(hlf_pkg::FUSE_ARRAY_WORD_OFS, 8'h9C);
		chk("prog_n", n_strobe[7:0], 8'h01);
		chk("prog_a", s_addr, 8'h21);
		chk("prog_d", s_data, 8'h9C);
		// two-wire mode and stuck clock
		wr(hlf_pkg::TIMEOUT_AND_IRQ_SETUP_OFS, 8'h10);
		wr(hlf_pkg::LINK_SELECT_OPTIONS_OFS, 8'hE0);
		cyc(4);
		chk("tw_mode", {5'h0, o_pins_link_role, o_continuous_high_speed_en,
			o_fast_plus_timing_en}, 8'h03);
		for (int k = 0; k < 2; k++) begin
			i_two_wire_clock <= 1'b0;
			cyc(15);
			i_two_wire_clock <= 1'b1;
			cyc(10);
		end
		chk("tmo_short", n_tmo[7:0], 8'h00);
		i_two_wire_clock <= 1'b0;
		cyc(60);
		i_two_wire_clock <= 1'b1;
		cyc(5);
		chk("tmo_long", n_tmo[7:0], 8'h01);
		// second reset in mid-run clears unlock and mode
		i_arst_n <= 1'b0;
		cyc(5);
		chk("rst2_o", {6'h0, o_fuse_unlocked, o_pins_link_role}, 8'h00);
		i_arst_n <= 1'b1;
		cyc(3);
		rd("rst2", hlf_pkg::LINK_SELECT_OPTIONS_OFS, 8'h00);
		chk("rst2_role", {7'h0, o_pins_link_role}, 8'h01);
		wrap_up();
	end
endmodule : hlf_regs_tb_top
